// ---- core/dcs_pkg.sv ----
// Shared constants, states and register map of the dual-channel converter serial link.
package dcs_pkg;

  // ---------------------------------------------------------------------------
  // Conversion framing
  // ---------------------------------------------------------------------------
  localparam int         RES_W          = 12;
  localparam int         WORD_W         = 16;
  localparam int         CTRL_W         = 8;
  localparam logic [3:0] FALL_TRACK     = 4'h1;
  localparam logic [3:0] FALL_HOLD      = 4'h4;
  localparam logic [3:0] FALL_DATA      = 4'h5;
  localparam logic [3:0] FALL_LAST      = 4'h0;
  localparam logic [3:0] RISE_CTRL_LAST = 4'h8;
  localparam logic [3:0] RISE_LAST      = 4'hf;
  localparam logic [3:0] CNT_STEP       = 4'h1;
  localparam logic [3:0] CNT_ZERO       = 4'h0;
  localparam logic [2:0] CTRL_MSB       = 3'h7;
  localparam int         ADDR_LOW_POS   = 3;
  localparam logic       CHAN_FIRST     = 1'b0;

  // ---------------------------------------------------------------------------
  // Link timing
  // ---------------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 8;
  localparam int         SCLK_PERIOD_NS = 160;
  localparam int         HALF_CYC       = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [4:0] HALF_LAST      = 5'(HALF_CYC - 1);
  localparam logic [4:0] HALF_STEP      = 5'h01;

  // ---------------------------------------------------------------------------
  // Controller register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0] OFS_CFG        = 4'h0;
  localparam logic [3:0] OFS_GO         = 4'h4;
  localparam logic [3:0] OFS_STAT       = 4'h8;
  localparam logic [3:0] OFS_DATA       = 4'hc;
  localparam int         CFG_W          = 12;
  localparam int         CFG_CNT_LSB    = 8;
  localparam logic [11:0] CFG_RST       = 12'h000;
  localparam int         STAT_BUSY      = 0;
  localparam int         STAT_VALID     = 1;

  typedef enum logic [2:0] {
    DEV_DOWN  = 3'b001,
    DEV_TRACK = 3'b010,
    DEV_HOLD  = 3'b100
  } dcs_dev_state_e;

  typedef enum logic [3:0] {
    HST_IDLE  = 4'b0001,
    HST_SETUP = 4'b0010,
    HST_SHIFT = 4'b0100,
    HST_TAIL  = 4'b1000
  } dcs_hst_state_e;

endpackage

// ---- core/dcs_if.sv ----
// Four-wire serial link between the converter and its controller.
`timescale 1ns/1ps
interface dcs_if;
  logic frame_sel_n;
  logic sclk;
  logic sdi;
  logic sdo_out;
  logic sdo_oe;
  logic sdo_line;

  // A pull-up holds the released output high whenever the converter lets go of it.
  assign sdo_line = sdo_oe ? sdo_out : 1'b1;

  modport dev (
    input  frame_sel_n,
    input  sclk,
    input  sdi,
    output sdo_out,
    output sdo_oe
  );

  modport host (
    output frame_sel_n,
    output sclk,
    output sdi,
    input  sdo_line
  );
endinterface

// ---- core/dcs_sync.sv ----
// Two-flop synchroniser for pins entering the core clock domain.
`timescale 1ns/1ps
module dcs_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] pin_s
);
  logic [W-1:0] meta_q;

  // The reset level should match the pin's idle level, so no false edge follows reset.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      pin_s  <= RST_VAL;
    end else begin
      meta_q <= pin;
      pin_s  <= meta_q;
    end
  end
endmodule

// ---- core/dcs_dev.sv ----
// Converter end: frame sequencer, control byte capture and result shifter.
//
// Operation
// - Track input for first three clocks
// - Convert twelve clocks, result MSB first from fifth
// - Host frames are whole multiples of sixteen
// - Output driven only while frame select low
// - Power down outside frames and between conversions
// - Retrack after sixteenth rise, hold fourth fall
// - Shift clock gated off while frame select high
// - Select fall acts as first fall, clock low
// - Clock idling high: first clock fall tracks
// - Capture control byte on first eight rises
// - Captured channel applies to the next conversion
// - Only address field bits five..three matter
// - Address low bit picks first or second
// - Host never sets middle address bit
// - Valid result in first frame, no warmup
// - First input is channel after reset
// - Result is plain unsigned binary code
// - Host keeps select to clock separation
// - Power down from sixteenth fall to next
// - Back-to-back conversions while select stays low
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module dcs_dev
  import dcs_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  dcs_if.dev                    link,
  input  wire logic [RES_W-1:0] analog_input_first,
  input  wire logic [RES_W-1:0] analog_input_second,
  output logic                  powered_down,
  output logic                  tracking,
  output logic                  converting,
  output logic                  active_channel,
  output logic [CTRL_W-1:0]     last_ctrl
);

  // ---------------------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------------------
  // Only the low address bit separates the two inputs; the other address
  // bits and the ignored bits are dropped here. A set middle bit is illegal
  // for the host, so whatever this picks then is acceptable.
  function automatic logic chan_of(input logic [CTRL_W-1:0] b);
    chan_of = b[ADDR_LOW_POS];
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] pins_s;
  logic       cs_s;
  logic       sclk_s;
  logic       sdi_s;

  dcs_sync #(.W(3), .RST_VAL(3'b110)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin      ({link.frame_sel_n, link.sclk, link.sdi}),
    .pin_s    (pins_s)
  );

  assign cs_s   = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  // ---------------------------------------------------------------------------
  // Internal shift clock
  // ---------------------------------------------------------------------------
  // Forcing the internal clock high while the frame is closed gates off all
  // edges, and a select fall with the clock low then yields the first
  // internal falling edge. With the clock idling high nothing happens until
  // the real clock falls.
  logic iclk_q;
  logic iclk;
  logic fall;
  logic rise;

  assign iclk = sclk_s | cs_s;
  assign fall = iclk_q & ~iclk;
  assign rise = ~iclk_q & iclk & ~cs_s;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      iclk_q <= 1'b1;
    end else begin
      iclk_q <= iclk;
    end
  end

  // ---------------------------------------------------------------------------
  // Edge counters
  // ---------------------------------------------------------------------------
  // Both counters wrap at sixteen, so a long frame simply starts the next
  // conversion on the edge after the sixteenth rise.
  logic [3:0] fcnt_q;
  logic [3:0] fcnt_d;
  logic [3:0] fcnt_nx;
  logic [3:0] rcnt_q;
  logic [3:0] rcnt_d;
  logic [3:0] rcnt_nx;

  assign fcnt_nx = fcnt_q + CNT_STEP;
  assign rcnt_nx = rcnt_q + CNT_STEP;
  assign fcnt_d  = cs_s ? CNT_ZERO : (fall ? fcnt_nx : fcnt_q);
  assign rcnt_d  = cs_s ? CNT_ZERO : (rise ? rcnt_nx : rcnt_q);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fcnt_q <= CNT_ZERO;
      rcnt_q <= CNT_ZERO;
    end else begin
      fcnt_q <= fcnt_d;
      rcnt_q <= rcnt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Track / hold / power-down sequencer
  // ---------------------------------------------------------------------------
  dcs_dev_state_e state_q;
  dcs_dev_state_e state_d;
  logic           at_track;
  logic           at_hold;
  logic           at_last;

  assign at_track = fall & (fcnt_nx == FALL_TRACK);
  assign at_hold  = fall & (fcnt_nx == FALL_HOLD);
  assign at_last  = fall & (fcnt_nx == FALL_LAST);

  always_comb begin
    state_d = state_q;
    if (cs_s) begin
      state_d = DEV_DOWN;
    end else begin
      unique case (1'b1)
        at_track: state_d = DEV_TRACK;
        at_hold:  state_d = DEV_HOLD;
        at_last:  state_d = DEV_DOWN;
        default:  state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= DEV_DOWN;
    end else begin
      state_q <= state_d;
    end
  end

  assign powered_down = (state_q == DEV_DOWN);
  assign tracking     = (state_q == DEV_TRACK);
  assign converting   = (state_q == DEV_HOLD);

  // ---------------------------------------------------------------------------
  // Control byte capture and channel selection
  // ---------------------------------------------------------------------------
  // The selection shifted in during one conversion is parked and only moved
  // to the active channel at the next track start, so the conversion in
  // progress never changes input halfway.
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_nx;
  logic              ctrl_shift;
  logic              ctrl_done;
  logic              next_chan_q;
  logic              cur_chan_q;

  assign ctrl_nx    = {ctrl_q[CTRL_W-2:0], sdi_s};
  assign ctrl_shift = rise & (rcnt_q < RISE_CTRL_LAST);
  assign ctrl_done  = rise & (rcnt_nx == RISE_CTRL_LAST);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q      <= '0;
      last_ctrl   <= '0;
      next_chan_q <= CHAN_FIRST;
      cur_chan_q  <= CHAN_FIRST;
    end else begin
      if (ctrl_shift) begin
        ctrl_q <= ctrl_nx;
      end
      if (ctrl_done) begin
        last_ctrl   <= ctrl_nx;
        next_chan_q <= chan_of(ctrl_nx);
      end
      if (at_track) begin
        cur_chan_q <= next_chan_q;
      end
    end
  end

  assign active_channel = cur_chan_q;

  // ---------------------------------------------------------------------------
  // Sample, result shifter and output pin
  // ---------------------------------------------------------------------------
  // The input is frozen on the fourth fall; the code is passed on unchanged
  // as an unsigned binary word. The last bit stands after the sixteenth fall
  // so the host can take it on the sixteenth rise.
  logic [RES_W-1:0] res_q;
  logic [RES_W-1:0] sample;
  logic             shift_out;
  logic             sdo_q;

  assign sample    = cur_chan_q ? analog_input_second : analog_input_first;
  assign shift_out = fall & ((fcnt_nx >= FALL_DATA) | (fcnt_nx == FALL_LAST));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_q <= '0;
      sdo_q <= 1'b0;
    end else begin
      if (cs_s) begin
        sdo_q <= 1'b0;
      end else if (at_hold) begin
        res_q <= sample;
        sdo_q <= 1'b0;
      end else if (shift_out) begin
        sdo_q <= res_q[RES_W-1];
        res_q <= {res_q[RES_W-2:0], 1'b0};
      end else if (fall) begin
        sdo_q <= 1'b0;
      end
    end
  end

  assign link.sdo_out = sdo_q;
  assign link.sdo_oe  = ~cs_s;

endmodule

// ---- core/dcs_host.sv ----
// Controller end: Avalon-MM register slave that runs framed conversions.
`timescale 1ns/1ps
module dcs_host
  import dcs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  dcs_if.host              link,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);

  // ---------------------------------------------------------------------------
  // Register slave
  // ---------------------------------------------------------------------------
  logic              req;
  logic              ack_q;
  logic              accept;
  logic              hit_cfg;
  logic              hit_go;
  logic              hit_stat;
  logic              hit_data;
  logic [CFG_W-1:0]  cfg_q;
  logic [WORD_W-1:0] data_q;
  logic              valid_q;
  logic              busy;
  logic              start;
  logic              word_done;
  logic [31:0]       rd_mux;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign accept          = req & ack_q;
  assign hit_cfg         = (avs_address == OFS_CFG);
  assign hit_go          = (avs_address == OFS_GO);
  assign hit_stat        = (avs_address == OFS_STAT);
  assign hit_data        = (avs_address == OFS_DATA);
  assign start           = accept & avs_write & hit_go & ~busy;
  assign rd_mux = hit_cfg  ? {20'h00000, cfg_q} :
                  hit_stat ? {30'h00000000, valid_q, busy} :
                  hit_data ? {16'h0000, data_q} : 32'h00000000;

  // Every access waits exactly one cycle; read data is latched then.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h00000000;
      cfg_q        <= CFG_RST;
      valid_q      <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        avs_readdata <= rd_mux;
      end
      if (accept & avs_write & hit_cfg) begin
        cfg_q <= avs_writedata[CFG_W-1:0];
      end
      // A new word beats a simultaneous read-clear.
      if (word_done) begin
        valid_q <= 1'b1;
      end else if (accept & avs_read & hit_data) begin
        valid_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Frame generator
  // ---------------------------------------------------------------------------
  // The clock idles high, so the converter starts tracking on our first
  // fall; a full period from select fall to that fall and a half period
  // from the last rise to select rise keep the select-to-clock separation.
  logic              sdo_s;
  logic [CTRL_W-1:0] ctrl_tx;
  dcs_hst_state_e    st_q;
  logic [4:0]        half_q;
  logic              tick;
  logic              cs_n_q;
  logic              sclk_q;
  logic              sdi_q;
  logic [3:0]        hfc_q;
  logic [3:0]        hrc_q;
  logic [3:0]        left_q;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] rx_nx;

  dcs_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin      (link.sdo_line),
    .pin_s    (sdo_s)
  );

  // The middle address bit is never sent, since a set bit leaves the result undefined.
  assign ctrl_tx   = cfg_q[CTRL_W-1:0] & ~(CTRL_W'(1) << (ADDR_LOW_POS + 1));
  assign busy      = (st_q != HST_IDLE);
  assign tick      = (half_q == HALF_LAST);
  assign rx_nx     = {rx_q[WORD_W-2:0], sdo_s};
  assign word_done = (st_q == HST_SHIFT) & tick & ~sclk_q & (hrc_q == RISE_LAST);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= HST_IDLE;
      half_q <= 5'h00;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b1;
      sdi_q  <= 1'b0;
      hfc_q  <= CNT_ZERO;
      hrc_q  <= CNT_ZERO;
      left_q <= CNT_ZERO;
      rx_q   <= '0;
      data_q <= '0;
    end else begin
      half_q <= (st_q == HST_IDLE || tick) ? 5'h00 : half_q + HALF_STEP;
      unique case (st_q)
        HST_IDLE: begin
          if (start) begin
            st_q   <= HST_SETUP;
            cs_n_q <= 1'b0;
            hfc_q  <= CNT_ZERO;
            hrc_q  <= CNT_ZERO;
            left_q <= cfg_q[CFG_W-1:CFG_CNT_LSB];
          end
        end
        HST_SETUP: begin
          if (tick) begin
            st_q <= HST_SHIFT;
          end
        end
        HST_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              // Control byte goes out MSB first on the first eight periods.
              sdi_q <= (hfc_q < RISE_CTRL_LAST) & ctrl_tx[CTRL_MSB - hfc_q[2:0]];
              hfc_q <= hfc_q + CNT_STEP;
            end else begin
              rx_q  <= rx_nx;
              hrc_q <= hrc_q + CNT_STEP;
              if (hrc_q == RISE_LAST) begin
                data_q <= rx_nx;
                if (left_q == CNT_ZERO) begin
                  st_q <= HST_TAIL;
                end else begin
                  left_q <= left_q - CNT_STEP;
                end
              end
            end
          end
        end
        HST_TAIL: begin
          if (tick) begin
            st_q   <= HST_IDLE;
            cs_n_q <= 1'b1;
            sdi_q  <= 1'b0;
          end
        end
      endcase
    end
  end

  assign link.frame_sel_n = cs_n_q;
  assign link.sclk        = sclk_q;
  assign link.sdi         = sdi_q;

endmodule

// ---- dv/dcs_checker.sv ----
// Concurrent checks on the four-wire link between the controller and the first converter.
`timescale 1ns/1ps
module dcs_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------------------
  // Edge counters inside a frame
  // ---------------------------------------------------------------------------
  logic       sclk_q;
  logic [4:0] fall_q;
  logic [3:0] rise_q;
  wire        fall_seen = sclk_q && !sclk && !frame_sel_n;
  wire        rise_seen = !sclk_q && sclk && !frame_sel_n;
  wire  [4:0] fall_d    = (fall_q == 5'h10) ? 5'h01 : fall_q + 5'h01;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q <= 1'b1;
      fall_q <= 5'h00;
    end else begin
      sclk_q <= sclk;
      fall_q <= frame_sel_n ? 5'h00 : (fall_seen ? fall_d : fall_q);
    end
  end

  // Wraps at sixteen, so a whole frame leaves it at zero.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_q <= 4'h0;
    end else begin
      rise_q <= frame_sel_n ? 4'h0 : (rise_seen ? rise_q + 4'h1 : rise_q);
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_oe_closed: assert property (frame_sel_n [*5] |-> !sdo_oe)
    else $error("output driven while frame closed");
  a_oe_open: assert property (!frame_sel_n [*5] |-> sdo_oe)
    else $error("output floating inside frame");
  a_lead_zero: assert property (rise_seen && fall_q inside {[5'h01:5'h04]} |-> !sdo_out && sdo_oe)
    else $error("leading bits not driven low");
  a_whole_frame: assert property ($rose(frame_sel_n) |-> rise_q == 4'h0)
    else $error("frame closed off a sixteen boundary");
  a_idle_high: assert property (frame_sel_n && $past(frame_sel_n) |-> sclk)
    else $error("shift clock low between frames");
  a_clk_gated: assert property (frame_sel_n [*2] |-> $stable(sclk))
    else $error("shift clock toggles outside frame");
  a_mid_bit_low: assert property (rise_seen && rise_q == 4'h3 |-> !sdi)
    else $error("middle address bit sent high");
  a_first_fall: assert property ($fell(frame_sel_n) |-> ##[19:21] $fell(sclk))
    else $error("first clock fall not after select setup");
  a_bit_stable: assert property (rise_seen |=> $stable(sdo_out) [*8])
    else $error("output bit moved while clock high");
endmodule

// ---- dv/dual_channel_adc_serial_frame_control_tb.sv ----
// Self-checking bench: controller and converter joined over the serial link.
`timescale 1ns/1ps
module dual_channel_adc_serial_frame_control_tb
  import dcs_pkg::*;
();
  logic              core_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [3:0]        avs_address = 4'h0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [RES_W-1:0]  ain1 = 12'ha5c;
  logic [RES_W-1:0]  ain2 = 12'h3b1;
  logic              powered_down;
  logic              tracking;
  logic              converting;
  logic              pd2;
  logic [CTRL_W-1:0] last_ctrl;
  logic              sclk_q = 1'b1;
  logic [4:0]        rcnt_q = 5'h00;
  logic [15:0]       sh_q = 16'h0;
  logic [15:0]       words[$];
  int                err_total = 0;
  int                num_checks = 0;

  dcs_if lnk ();
  dcs_if lnk2 ();

  always #4 core_clk = ~core_clk;

  dcs_host dcs_host_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(lnk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  dcs_dev dcs_dev_inst (.core_clk(core_clk), .sys_rst(sys_rst), .link(lnk), .analog_input_first(ain1),
    .analog_input_second(ain2), .powered_down(powered_down), .tracking(tracking),
    .converting(converting), .active_channel(), .last_ctrl(last_ctrl));
  // Second converter, driven by the bench with the clock idling low.
  dcs_dev dcs_dev_inst2 (.core_clk(core_clk), .sys_rst(sys_rst), .link(lnk2), .analog_input_first(ain1),
    .analog_input_second(ain2), .powered_down(pd2), .tracking(), .converting(), .active_channel(),
    .last_ctrl());
  dcs_checker dcs_checker_inst (.core_clk(core_clk), .sys_rst(sys_rst), .frame_sel_n(lnk.frame_sel_n),
    .sclk(lnk.sclk), .sdi(lnk.sdi), .sdo_out(lnk.sdo_out), .sdo_oe(lnk.sdo_oe), .sdo_line(lnk.sdo_line));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Wire monitor: collects words and mode at every host sampling edge
  // ---------------------------------------------------------------------------
  always @(posedge core_clk) begin : wire_mon
    logic [4:0] k;
    k = (rcnt_q == 5'h10) ? 5'h01 : rcnt_q + 5'h01;
    sclk_q <= lnk.sclk;
    if (lnk.frame_sel_n) begin
      rcnt_q <= 5'h00;
    end else if (lnk.sclk && !sclk_q) begin
      rcnt_q <= k;
      sh_q <= {sh_q[14:0], lnk.sdo_line};
      if (k == 5'h10) begin
        words.push_back({sh_q[14:0], lnk.sdo_line});
      end
      chk(32'({powered_down, tracking, converting}), (k < 5'h04) ? 32'h2 : (k < 5'h10) ? 32'h1 : 32'h4, "mode");
    end
  end

  // ---------------------------------------------------------------------------
  // Bus access and frame tasks
  // ---------------------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
      n++;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
    chk(32'(n), 32'h1, "wait states");
  endtask

  task automatic run(input logic [11:0] cfg, input logic [11:0] exp);
    logic [31:0] q;
    int          n;
    n = 0;
    bus(1'b1, OFS_CFG, 32'(cfg), q);
    bus(1'b1, OFS_GO, 32'h1, q);
    bus(1'b0, OFS_STAT, 32'h0, q);
    chk(q, 32'h1, "busy");
    while (q[STAT_BUSY] !== 1'b0 && n < 2000) begin
      bus(1'b0, OFS_STAT, 32'h0, q);
      n++;
    end
    chk(q, 32'h2, "valid");
    chk(32'(powered_down), 32'h1, "power down");
    chk(32'(last_ctrl), 32'(cfg[7:0] & 8'hef), "ctrl byte");
    bus(1'b0, OFS_DATA, 32'h0, q);
    chk(q, 32'(exp), "result");
    bus(1'b0, OFS_STAT, 32'h0, q);
    chk(q, 32'h0, "valid clear");
  endtask

  task automatic t_regs;
    logic [31:0] q;
    bus(1'b0, OFS_CFG, 32'h0, q);
    chk(q, 32'(CFG_RST), "cfg reset");
    bus(1'b1, 4'h2, 32'hffffffff, q);
    bus(1'b0, 4'h2, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    bus(1'b1, OFS_CFG, 32'hffffffff, q);
    bus(1'b0, OFS_CFG, 32'h0, q);
    chk(q, 32'hfff, "cfg width");
    $display("done regs");
  endtask

  task automatic t_chan;
    run(12'h008, ain1);
    run(12'h000, ain2);
    run(12'h0df, ain1);
    run(12'h0e7, ain2);
    run(12'h000, ain1);
    $display("done chan");
  endtask

  task automatic t_codes;
    logic [11:0] codes[3];
    codes = '{12'h000, 12'hfff, 12'h801};
    foreach (codes[i]) begin
      ain1 <= codes[i];
      run(12'h000, codes[i]);
    end
    $display("done codes");
  endtask

  task automatic t_multi;
    words.delete();
    run(12'h208, ain2);
    chk(32'(words.size()), 32'h3, "word count");
    chk(32'(words[0]), 32'(ain1), "word 1");
    chk(32'(words[1]), 32'(ain2), "word 2");
    chk(32'(words[2]), 32'(ain2), "word 3");
    $display("done multi");
  endtask

  task automatic t_idle_low;
    logic [15:0] w;
    w = 16'h0;
    for (int i = 0; i < 6; i++) begin
      lnk2.sclk <= ~lnk2.sclk;
      repeat (10) @(posedge core_clk);
    end
    lnk2.frame_sel_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      repeat (10) @(posedge core_clk);
      lnk2.sclk <= 1'b1;
      w = {w[14:0], lnk2.sdo_line};
      repeat (10) @(posedge core_clk);
      lnk2.sclk <= 1'b0;
    end
    lnk2.frame_sel_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk(32'(w), 32'(ain1), "idle low word");
    chk(32'(pd2), 32'h1, "idle low power down");
    chk(32'(lnk2.sdo_oe), 32'h0, "idle low float");
    chk(32'(lnk2.sdo_line), 32'h1, "idle low released");
    $display("done idle low");
  endtask

  initial begin
    lnk2.frame_sel_n = 1'b1;
    lnk2.sclk = 1'b0;
    lnk2.sdi = 1'b0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_chan;
    t_codes;
    t_multi;
    t_idle_low;
    test_done;
  end

  // Runs take about 4300 cycles; this leaves a wide margin.
  initial begin
    #500000;
    err_total++;
    test_done;
  end
endmodule
